/* src/fiag_defs.svh */
`ifndef FIAG_DEFS_SVH
`define FIAG_DEFS_SVH
// flash map
`define FIAG_FLASH_TOP      14'h3FFF
`define FIAG_FLASH_BASE     14'h0000
`define FIAG_VEC_END        14'h006F
`define FIAG_LOCK_END       14'h01FF
`define FIAG_ALL_END        14'h3EFF
`define FIAG_FREE_BASE      14'h3F00
`define FIAG_FREE_END       14'h3FEF
`define FIAG_CFG_BASE       14'h3FF0
`define FIAG_CFG_OPEN_END   14'h3FF7
`define FIAG_CHK_LO         14'h3FF0
`define FIAG_CHK_HI         14'h3FF1
`define FIAG_BG_ADDR        14'h3FFB
`define FIAG_CFGL_ADDR      14'h3FFD
`define FIAG_CFGH_ADDR      14'h3FFF
`define FIAG_IAP16_LO       14'h3000
`define FIAG_IAP16_HI       14'h3FEF
`define FIAG_IAP8_LO        14'h1000
`define FIAG_IAP8_HI        14'h1FEF
`define FIAG_EMU_LO         14'h2D00
`define FIAG_EMU_HI         14'h2FFF
`define FIAG_LOCK_BIT       1
// command values
`define FIAG_ALL_KEY        8'h65
`define FIAG_WE_KEY         8'h47
// apb byte offsets
`define FIAG_OFS_SOFTWARE_COMMAND_REG      12'h000
`define FIAG_OFS_WREN       12'h004
`define FIAG_OFS_CTRL_LOW   12'h008
`define FIAG_OFS_BANDGAP    12'h00C
`define FIAG_OFS_STATUS     12'h010
`define FIAG_OFS_CHECKSUM   12'h014
`endif

/* src/fiag_pkg.sv */
package fiag_pkg;
  typedef enum logic [1:0] {
    FIAG_LOAD_LOW  = 2'h0,
    FIAG_LOAD_BG   = 2'h1,
    FIAG_LOAD_HIGH = 2'h3,
    FIAG_RUN       = 2'h2
  } fiag_state_t;
  typedef struct packed {
    logic        valid;
    logic        is_data;
    logic        write;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } fiag_req_t;
  typedef struct packed {
    logic        req;
    logic        write;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } fiag_flash_t;
endpackage : fiag_pkg

/* src/fiag_guard.sv */
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "fiag_defs.svh"
// Function
// - decode one 16K byte flash space, 0000h to 3FFFh, into sectors.
// - top 16 bytes are configuration, loaded into controls after reset; only 3FFDh, 3FFBh and 3FFFh are loaded at boot.
// - 0000h to 006Fh hold reset and interrupt vectors.
// - 16K variant uses 3000h to 3FEFh as data programming area.
// - 8K variant uses 1000h to 1FEFh as data programming area.
// - single byte writes need no prior page erase.
// - after reset 248 bytes are writable; controls may widen this.
// - locked sector: lock blocks all; else code reads, moves need flag.
// - 0200h to 3EFFh: code reads always, data moves only with flag.
// - 3F00h to 3FEFh always allow code reads and data moves.
// - config: 3FF0h-3FF7h open, 3FF8h-3FFEh need flag, 3FFFh never.
// - writing 65h to command register sets flag, other values clear.
// - low and bandgap config bytes load into control registers.
// - 3FF0h and 3FF1h hold the code checksum, low then high.
// - flash writes accepted only while write enable flag set by 47h.
// - lock bit is bit 1 of top configuration byte.
// - command register bit 0 reads back the all-area flag.
module fiag_guard #(
  parameter bit IS_16K = 1'b1
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire fiag_pkg::fiag_req_t   cpu_req,
  output logic      [7:0]        cpu_rdata,
  output logic                   cpu_ack,
  output logic                   cpu_denied,
  output fiag_pkg::fiag_flash_t  flash_cmd,
  input  wire logic [7:0]        flash_rdata,
  output logic                   boot_done
);
  import fiag_pkg::*;

  fiag_state_t state;
  logic        all_area_write_flag;
  logic        flash_write_enable_flag;
  logic        code_read_lock_bit;
  logic [7:0]  ctrl_low;
  logic [7:0]  bandgap_ctrl;
  logic [7:0]  chk_lo;
  logic [7:0]  chk_hi;
  logic        chk_phase;
  logic        apb_go;
  logic        mapped;
  logic [31:0] next_rdata;
  logic        allowed;
  logic        grant;
  logic        core_issued;
  logic [2:0]  region;

  function automatic logic access_ok(input logic [13:0] a,
                                     input logic data_mv,
                                     input logic lock,
                                     input logic all_flag);
    logic ok;
    ok = 1'b1;
    if (a <= `FIAG_LOCK_END) begin
      ok = !lock && (!data_mv || all_flag);
    end else if (a <= `FIAG_ALL_END) begin
      ok = !data_mv || all_flag;
    end else if (a <= `FIAG_FREE_END) begin
      ok = 1'b1;
    end else if (a <= `FIAG_CFG_OPEN_END) begin
      ok = 1'b1;
    end else if (a < `FIAG_FLASH_TOP) begin
      ok = !data_mv || all_flag;
    end else begin
      ok = !data_mv;
    end
    return ok;
  endfunction : access_ok

  function automatic logic in_span(input logic [13:0] a,
                                   input logic [13:0] lo,
                                   input logic [13:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_span

  // 8K parts get no address wrap; the decode spans all 14 bits in both variants
  assign allowed = access_ok(cpu_req.addr, cpu_req.is_data,
                             code_read_lock_bit, all_area_write_flag);
  // writes also need the enable flag before they may reach flash
  assign grant = allowed && (!cpu_req.write || flash_write_enable_flag);

  // last core address class, so software can see where a denial landed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      region <= 3'h0;
    end else if (clk_en && state == FIAG_RUN && cpu_req.valid) begin
      region[2] <= in_span(cpu_req.addr, `FIAG_FLASH_BASE,
                           `FIAG_VEC_END);
      region[1] <= IS_16K ?
                   in_span(cpu_req.addr, `FIAG_IAP16_LO,
                           `FIAG_IAP16_HI) :
                   in_span(cpu_req.addr, `FIAG_IAP8_LO,
                           `FIAG_IAP8_HI);
      region[0] <= in_span(cpu_req.addr, `FIAG_FREE_BASE,
                           `FIAG_FREE_END);
    end
  end

  // boot loader: read config bytes one per cycle before serving the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FIAG_LOAD_LOW;
    end else if (clk_en) begin
      unique case (state)
        FIAG_LOAD_LOW:  state <= FIAG_LOAD_BG;
        FIAG_LOAD_BG:   state <= FIAG_LOAD_HIGH;
        FIAG_LOAD_HIGH: state <= FIAG_RUN;
        FIAG_RUN:       state <= FIAG_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done <= 1'b0;
    end else if (clk_en) begin
      // rises with the lock capture; a core access in the first FIAG_RUN cycle still sees the reset lock value
      boot_done <= (state == FIAG_RUN);
    end
  end

  // checksum bytes sampled once the core is idle, so boot stays short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_phase <= 1'b0;
      chk_lo    <= 8'h00;
      chk_hi    <= 8'h00;
    end else if (clk_en && state == FIAG_RUN && !cpu_req.valid) begin
      chk_phase <= !chk_phase;
      if (flash_cmd.req && !flash_cmd.write &&
          flash_cmd.addr == `FIAG_CHK_LO) begin
        chk_lo <= flash_rdata;
      end
      if (flash_cmd.req && !flash_cmd.write &&
          flash_cmd.addr == `FIAG_CHK_HI) begin
        chk_hi <= flash_rdata;
      end
    end
  end

  // flash port: boot reads, then core accesses; denied ones never issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cmd <= '0;
    end else if (clk_en) begin
      flash_cmd <= '0;
      unique case (state)
        FIAG_LOAD_LOW: begin
          flash_cmd.req  <= 1'b1;
          flash_cmd.addr <= `FIAG_CFGL_ADDR;
        end
        FIAG_LOAD_BG: begin
          flash_cmd.req  <= 1'b1;
          flash_cmd.addr <= `FIAG_BG_ADDR;
        end
        FIAG_LOAD_HIGH: begin
          flash_cmd.req  <= 1'b1;
          flash_cmd.addr <= `FIAG_CFGH_ADDR;
        end
        FIAG_RUN: begin
          if (cpu_req.valid && grant) begin
            flash_cmd.req   <= 1'b1;
            flash_cmd.write <= cpu_req.is_data && cpu_req.write;
            flash_cmd.addr  <= cpu_req.addr;
            flash_cmd.wdata <= cpu_req.wdata;
          end else if (!cpu_req.valid) begin
            flash_cmd.req  <= 1'b1;
            flash_cmd.addr <= chk_phase ? `FIAG_CHK_HI : `FIAG_CHK_LO;
          end
        end
      endcase
    end
  end

  // config captured one cycle after its read, the flash command is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_low           <= 8'h00;
      bandgap_ctrl       <= 8'h00;
      code_read_lock_bit <= 1'b0;
    end else if (clk_en) begin
      if (state == FIAG_LOAD_BG) begin
        ctrl_low <= flash_rdata;
      end else if (apb_go && pwrite && paddr == `FIAG_OFS_CTRL_LOW) begin
        ctrl_low <= pwdata[7:0];
      end
      if (state == FIAG_LOAD_HIGH) begin
        bandgap_ctrl <= flash_rdata;
      end else if (apb_go && pwrite && paddr == `FIAG_OFS_BANDGAP) begin
        bandgap_ctrl <= pwdata[7:0];
      end
      // no software path: the lock comes from flash only
      if (state == FIAG_RUN && !boot_done) begin
        code_read_lock_bit <= flash_rdata[`FIAG_LOCK_BIT];
      end
    end
  end

  assign apb_go = psel && penable && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_area_write_flag     <= 1'b0;
      flash_write_enable_flag <= 1'b0;
    end else if (clk_en && apb_go && pwrite) begin
      if (paddr == `FIAG_OFS_SOFTWARE_COMMAND_REG) begin
        all_area_write_flag <= (pwdata[7:0] == `FIAG_ALL_KEY);
      end
      if (paddr == `FIAG_OFS_WREN) begin
        flash_write_enable_flag <= (pwdata[7:0] == `FIAG_WE_KEY);
      end
    end
  end

  // idle scrub reads also raise req; only core slots may be acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_issued <= 1'b0;
    end else if (clk_en) begin
      core_issued <= state == FIAG_RUN && cpu_req.valid && grant;
    end
  end

  // core ack two cycles after the request, denial after one; denied reads give zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack    <= 1'b0;
      cpu_denied <= 1'b0;
      cpu_rdata  <= 8'h00;
    end else if (clk_en) begin
      cpu_ack    <= core_issued && cpu_req.valid;
      cpu_denied <= state == FIAG_RUN && cpu_req.valid && !grant;
      cpu_rdata  <= 8'h00;
      if (core_issued && !flash_cmd.write && cpu_req.valid) begin
        cpu_rdata <= flash_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped     = 1'b1;
    case (paddr)
      `FIAG_OFS_SOFTWARE_COMMAND_REG:    next_rdata[0] = all_area_write_flag;
      `FIAG_OFS_WREN:     next_rdata[7] = flash_write_enable_flag;
      `FIAG_OFS_CTRL_LOW: next_rdata[7:0] = ctrl_low;
      `FIAG_OFS_BANDGAP:  next_rdata[7:0] = bandgap_ctrl;
      `FIAG_OFS_STATUS:   next_rdata[5:0] = {region, IS_16K, boot_done,
                                             code_read_lock_bit};
      `FIAG_OFS_CHECKSUM: next_rdata[15:0] = {chk_hi, chk_lo};
      default:            mapped = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= (psel && !pwrite && !pready) ? next_rdata : 32'h0000_0000;
    end
  end

  lock_blocks_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_RUN && cpu_req.valid && code_read_lock_bit &&
    cpu_req.addr <= `FIAG_LOCK_END |=> cpu_denied)
    else $error("locked sector access not denied");
  all_area_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_RUN && cpu_req.valid && cpu_req.is_data &&
    !all_area_write_flag && cpu_req.addr > `FIAG_LOCK_END &&
    cpu_req.addr <= `FIAG_ALL_END |=> cpu_denied)
    else $error("all-area move allowed without flag");
  free_open_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_RUN && cpu_req.valid && !cpu_req.write &&
    cpu_req.addr > `FIAG_ALL_END && cpu_req.addr <= `FIAG_FREE_END
    |=> !cpu_denied)
    else $error("free sector read denied");
  cfg_top_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_RUN && cpu_req.valid && cpu_req.is_data &&
    cpu_req.addr == `FIAG_FLASH_TOP |=> cpu_denied)
    else $error("top config byte moved");
  cfg_open_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_RUN && cpu_req.valid && !cpu_req.write &&
    cpu_req.addr >= `FIAG_CFG_BASE && cpu_req.addr <= `FIAG_CFG_OPEN_END
    |=> !cpu_denied)
    else $error("open config byte denied");
  flag_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && apb_go && pwrite && paddr == `FIAG_OFS_SOFTWARE_COMMAND_REG
    |=> all_area_write_flag == ($past(pwdata[7:0]) == `FIAG_ALL_KEY))
    else $error("all-area flag wrong after command");
  denied_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && cpu_req.valid && cpu_req.write && !flash_write_enable_flag
    |=> !flash_cmd.write)
    else $error("write issued without enable");
  boot_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_LOAD_BG |=> ctrl_low == $past(flash_rdata))
    else $error("low config not loaded");
  lock_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_RUN && !boot_done
    |=> code_read_lock_bit == $past(flash_rdata[`FIAG_LOCK_BIT]))
    else $error("lock bit not taken from top byte");
  boot_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    boot_done |=> boot_done)
    else $error("boot done dropped");
  vec_region_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && state == FIAG_RUN && cpu_req.valid &&
    cpu_req.addr <= `FIAG_VEC_END |=> region[2])
    else $error("vector access not classed");
  ack_deny_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(cpu_ack && cpu_denied))
    else $error("grant and denial together");
  denied_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_denied |-> cpu_rdata == 8'h00)
    else $error("denied read leaked data");
endmodule : fiag_guard
`default_nettype wire

/* verification/fiag_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fiag_flash_model (
  input  wire logic                  pclk,
  input  wire fiag_pkg::fiag_flash_t cmd,
  output logic [7:0]                 rdata
);
  import fiag_pkg::*;
  logic [7:0] mem [0:16383];
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'hA5;
    mem[14'h3FFF] = 8'h00;
  end
  // combinational read, the guard expects data in the same cycle
  assign rdata = mem[cmd.addr];
  // byte write lands at once, no erase step needed
  always @(posedge pclk) begin
    if (cmd.req && cmd.write) mem[cmd.addr] <= cmd.wdata;
  end
endmodule : fiag_flash_model
`default_nettype wire

/* verification/fiag_guard_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module fiag_guard_bench;
  import fiag_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  fiag_req_t   req;
  fiag_flash_t fcmd;
  logic [7:0]  cpu_rdata, frd;
  logic        cpu_ack, cpu_denied, boot_done;
  int          fails, compares;
  localparam logic [13:0] AT [11] = '{14'h0000, 14'h01FF, 14'h0200,
    14'h3EFF, 14'h3F00, 14'h3FEF, 14'h3FF0, 14'h3FF7, 14'h3FF8,
    14'h3FFE, 14'h3FFF};
  always #2 pclk = ~pclk;
  fiag_guard u_fiag_guard (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(req), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
    .cpu_denied(cpu_denied), .flash_cmd(fcmd), .flash_rdata(frd),
    .boot_done(boot_done));
  fiag_flash_model u_fiag_flash_model (.pclk(pclk), .cmd(fcmd), .rdata(frd));
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      complete_run();
    end
  endtask : bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    bound(n, 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // holding the request may repeat it, so let trailing answers drain
  task automatic core(input logic dm, input logic w, input logic [13:0] a,
                      input logic [7:0] d, output logic g,
                      output logic [7:0] rd);
    int n;
    req <= '{1'b1, dm, w, a, d};
    n = 0;
    do begin @(posedge pclk); n++; end
      while (cpu_ack !== 1'b1 && cpu_denied !== 1'b1 && n < 20);
    bound(n, 20);
    g = cpu_ack;
    rd = cpu_rdata;
    req <= '0;
    repeat (4) @(posedge pclk);
  endtask : core
  function automatic logic ok(logic [13:0] a, logic dm, logic lk, logic fl);
    if (a <= 14'h01FF) return !lk && (!dm || fl);
    if (!dm) return 1'b1;
    if (a <= 14'h3EFF || (a >= 14'h3FF8 && a <= 14'h3FFE)) return fl;
    return a != 14'h3FFF;
  endfunction : ok
  task automatic do_reset;
    int n;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (boot_done !== 1'b1 && n < 20);
    bound(n, 20);
  endtask : do_reset
  task automatic boot_regs(input logic lk);
    logic [31:0] r;
    logic        e;
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk(r[7:0], u_fiag_flash_model.mem[14'h3FFD], "low cfg");
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk(r[7:0], u_fiag_flash_model.mem[14'h3FFB], "bandgap");
    apb(1'b0, 12'h014, 32'h0, r, e);
    chk(r[15:0], {u_fiag_flash_model.mem[14'h3FF1],
        u_fiag_flash_model.mem[14'h3FF0]}, "checksum");
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk(r[2:0], {2'b11, lk}, "status");
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(e, 1'b1, "unmapped");
    apb(1'b1, 12'h008, 32'h3C, r, e);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk(r[7:0], 8'h3C, "sw low cfg");
  endtask : boot_regs
  task automatic perm(input logic lk);
    logic [31:0] r;
    logic        e, g, x;
    logic [7:0]  d;
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, 12'h000, f ? 32'h65 : 32'h64, r, e);
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk(r[0], f[0], "flag");
      for (int i = 0; i < 11; i++) begin
        for (int m = 0; m < 2; m++) begin
          x = ok(AT[i], m[0], lk, f[0]);
          core(m[0], 1'b0, AT[i], 8'h00, g, d);
          chk(g, x, "grant");
          chk(d, x ? u_fiag_flash_model.mem[AT[i]] : 8'h00, "rd");
        end
      end
    end
  endtask : perm
  task automatic writes;
    logic [31:0] r;
    logic        e, g;
    logic [7:0]  d;
    apb(1'b1, 12'h000, 32'h0, r, e);
    apb(1'b1, 12'h004, 32'h47, r, e);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk(r[7], 1'b1, "write enable");
    core(1'b1, 1'b1, 14'h3F00, 8'h3C, g, d);
    chk(g, 1'b1, "free write");
    chk(u_fiag_flash_model.mem[14'h3F00], 8'h3C, "free byte");
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk(r[5:3], 3'b011, "region");
    core(1'b1, 1'b1, 14'h0200, 8'h3C, g, d);
    chk(g, 1'b0, "all-area write");
    chk(u_fiag_flash_model.mem[14'h0200], 8'hA5, "kept byte");
    apb(1'b1, 12'h004, 32'h0, r, e);
    core(1'b1, 1'b1, 14'h3F01, 8'h3C, g, d);
    chk(u_fiag_flash_model.mem[14'h3F01], 8'hA4, "no enable");
  endtask : writes
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    req = '0;
    fails = 0;
    compares = 0;
    do_reset();
    boot_regs(1'b0);
    perm(1'b0);
    writes();
    u_fiag_flash_model.mem[14'h3FFF] = 8'h02;
    do_reset();
    boot_regs(1'b1);
    perm(1'b1);
    complete_run();
  end
endmodule : fiag_guard_bench
`default_nettype wire
